// ==== adc_seq_pkg.sv ====
// Purpose: constants and types for the conversion sequencer
// Assumes: one core clock, standing in for the oscillator
// Notes: register offsets are byte addresses on the APB bus
// Function
// - start write begins conversion, aborting current one
// - sequence starts in the next machine cycle
// - busy flag set with the start write
// - conversion lasts exactly fifteen machine cycles
// - continuous mode restarts after completion automatically
// - sample channel five cycles, then hold
// - approximation steps in cycles six to thirteen
// - cycle fifteen loads result, clears busy
// - done flag set at end of cycle eleven
// - three select bits choose one of eight inputs
// - control bit three selects continuous or single
// - bit four reads busy, write ignored
// - bit seven routes baud generator to serial
// - machine cycles from half-rate clock generator
// - control bits five and six reserved, zero
// - start write value ignored, reads return zero
package adc_seq_pkg;
  // ****************************************************
  // register map
  // ****************************************************
  localparam logic [11:0] CONTROL_OFFSET = 12'h0d8;
  localparam logic [11:0] START_OFFSET = 12'h0dc;
  localparam logic [11:0] RESULT_OFFSET = 12'h0e0;
  localparam logic [11:0] IRQ_STATUS_OFFSET = 12'h0e4;
  localparam logic [11:0] IRQ_MASK_OFFSET = 12'h0e8;
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [7:0] IRQ_MASK_RESET = 8'h00;
  // control fields
  localparam int CHAN_LSB = 0;
  localparam int MODE_BIT = 3;
  localparam int BUSY_BIT = 4;
  localparam int BAUD_BIT = 7;
  localparam logic [7:0] CONTROL_WMASK = 8'h8f;
  localparam int DONE_BIT = 0;
  // ****************************************************
  // timing
  // ****************************************************
  localparam int OSC_FREQ_MHZ = 12;
  localparam int CORE_CLK_MHZ = 40;
  localparam int STATES_PER_MC = 6;
  localparam logic [2:0] LAST_STATE = 3'(STATES_PER_MC - 1);
  localparam logic [3:0] SAMPLE_LAST = 4'h5;
  localparam logic [3:0] CONV_FIRST = 4'h6;
  localparam logic [3:0] SAR_LAST = 4'hd;
  localparam logic [3:0] IRQ_CYCLE = 4'hb;
  localparam logic [3:0] FINAL_CYCLE = 4'hf;
  localparam logic [3:0] PRE_FINAL = 4'he;
  // clock count seen at the last edge of cycle fifteen: 15 x 12 - 1
  localparam logic [7:0] CONV_LAST_CLK = 8'hb3;
  localparam logic [7:0] SAR_FIRST_TRIAL = 8'h80;
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_SAMPLE = 2'b01,
    ST_CONVERT = 2'b11,
    ST_FINISH = 2'b10
  } seq_state_t;
endpackage

// ==== adc_conversion_sequencer.sv ====
// Purpose: timing and control for an 8-bit successive-approximation
//   converter, reached over APB
// Assumes: comparator output arrives asynchronously from the analog
//   side; core clock runs at 40 MHz in place of the 12 MHz oscillator
// Notes: one machine cycle is twelve core clocks
//
// The APB interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer (
  input wire logic I_CORE_CLK,
  input wire logic I_RST,
  input wire logic I_PSEL,
  input wire logic I_PENABLE,
  input wire logic I_PWRITE,
  input wire logic [11:0] I_PADDR,
  input wire logic [31:0] I_PWDATA,
  output logic [31:0] O_PRDATA,
  output logic O_PREADY,
  output logic O_PSLVERR,
  input wire logic I_COMP_HIGH,
  output logic [2:0] O_CHANNEL_SEL,
  output logic O_SAMPLE_CLOSED,
  output logic [7:0] O_DAC_CODE,
  output logic O_BAUD_GEN_SELECT,
  output logic O_IRQ
);

  // ****************************************************
  // bus decode
  // ****************************************************
  logic setup_phase;
  logic access_wr;
  logic hit_control;
  logic hit_start;
  logic hit_result;
  logic hit_status;
  logic hit_mask;
  logic mapped;
  logic start_wr;
  logic status_clr;

  always_comb begin
    hit_control = 1'b0;
    hit_start = 1'b0;
    hit_result = 1'b0;
    hit_status = 1'b0;
    hit_mask = 1'b0;
    if (I_PADDR == adc_seq_pkg::CONTROL_OFFSET) begin
      hit_control = 1'b1;
    end else if (I_PADDR == adc_seq_pkg::START_OFFSET) begin
      hit_start = 1'b1;
    end else if (I_PADDR == adc_seq_pkg::RESULT_OFFSET) begin
      hit_result = 1'b1;
    end else if (I_PADDR == adc_seq_pkg::IRQ_STATUS_OFFSET) begin
      hit_status = 1'b1;
    end else if (I_PADDR == adc_seq_pkg::IRQ_MASK_OFFSET) begin
      hit_mask = 1'b1;
    end
  end

  assign mapped = hit_control | hit_start | hit_result | hit_status |
                  hit_mask;
  assign setup_phase = I_PSEL & ~I_PENABLE;
  assign access_wr = I_PSEL & I_PENABLE & I_PWRITE;
  // any write counts, whatever the data
  assign start_wr = access_wr & hit_start;
  assign status_clr = access_wr & hit_status & I_PWDATA[0];
  // zero wait states keeps the core's view of machine cycles simple
  assign O_PREADY = 1'b1;
  assign O_PSLVERR = I_PSEL & I_PENABLE & ~mapped;

  // ****************************************************
  // machine cycle generator
  // ****************************************************
  logic phase;
  logic [2:0] mc_state;
  logic mc_end;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      phase <= 1'b0;
    end else begin
      phase <= ~phase;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      mc_state <= 3'h0;
    end else if (phase) begin
      if (mc_state == adc_seq_pkg::LAST_STATE) begin
        mc_state <= 3'h0;
      end else begin
        mc_state <= mc_state + 3'h1;
      end
    end
  end

  assign mc_end = phase & (mc_state == adc_seq_pkg::LAST_STATE);

  // ****************************************************
  // comparator synchroniser
  // ****************************************************
  logic comp_meta;
  logic comp_sync;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      comp_meta <= 1'b0;
      comp_sync <= 1'b0;
    end else begin
      comp_meta <= I_COMP_HIGH;
      comp_sync <= comp_meta;
    end
  end

  // ****************************************************
  // control register
  // ****************************************************
  logic [7:0] control;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      control <= adc_seq_pkg::CONTROL_RESET;
    end else if (access_wr && hit_control) begin
      // busy and reserved bits are never stored
      control <= I_PWDATA[7:0] & adc_seq_pkg::CONTROL_WMASK;
    end
  end

  logic cont_mode;
  assign cont_mode = control[adc_seq_pkg::MODE_BIT];

  // ****************************************************
  // sequence counter
  // ****************************************************
  adc_seq_pkg::seq_state_t state;
  logic [3:0] cyc;
  logic pending;

  // a start waits for the next machine cycle boundary
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      pending <= 1'b0;
    end else if (start_wr) begin
      pending <= 1'b1;
    end else if (mc_end) begin
      pending <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      cyc <= 4'h0;
    end else if (start_wr) begin
      cyc <= 4'h0;
    end else if (mc_end) begin
      if (pending) begin
        cyc <= 4'h1;
      end else if (cyc == adc_seq_pkg::FINAL_CYCLE) begin
        cyc <= cont_mode ? 4'h1 : 4'h0;
      end else if (cyc != 4'h0) begin
        cyc <= cyc + 4'h1;
      end
    end
  end

  always_comb begin
    if (cyc == 4'h0) begin
      state = adc_seq_pkg::ST_IDLE;
    end else if (cyc <= adc_seq_pkg::SAMPLE_LAST) begin
      state = adc_seq_pkg::ST_SAMPLE;
    end else if (cyc == adc_seq_pkg::FINAL_CYCLE) begin
      state = adc_seq_pkg::ST_FINISH;
    end else begin
      state = adc_seq_pkg::ST_CONVERT;
    end
  end

  // ****************************************************
  // busy flag
  // ****************************************************
  logic busy;
  logic enter_final;

  assign enter_final = mc_end & ~pending &
                       (cyc == adc_seq_pkg::PRE_FINAL);

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      busy <= 1'b0;
    end else if (start_wr) begin
      busy <= 1'b1;
    end else if (enter_final) begin
      busy <= 1'b0;
    end else if (mc_end && cont_mode && !pending &&
                 cyc == adc_seq_pkg::FINAL_CYCLE) begin
      busy <= 1'b1;
    end
  end

  // ****************************************************
  // successive approximation
  // ****************************************************
  logic [7:0] sar;
  logic [7:0] sar_mask;
  logic [7:0] result;
  logic sar_step;

  assign sar_mask = adc_seq_pkg::SAR_FIRST_TRIAL >>
                    (cyc - adc_seq_pkg::CONV_FIRST);
  assign sar_step = mc_end & ~pending &
                    (cyc >= adc_seq_pkg::CONV_FIRST) &
                    (cyc <= adc_seq_pkg::SAR_LAST);

  // one bit per machine cycle; the last spare cycle absorbs
  // comparator settling before the transfer
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      sar <= 8'h00;
    end else if (start_wr) begin
      sar <= 8'h00;
    end else if (mc_end && !pending &&
                 cyc == adc_seq_pkg::SAMPLE_LAST) begin
      sar <= adc_seq_pkg::SAR_FIRST_TRIAL;
    end else if (sar_step) begin
      sar <= (comp_sync ? sar : (sar & ~sar_mask)) |
             (sar_mask >> 1);
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      result <= adc_seq_pkg::RESULT_RESET;
    end else if (enter_final) begin
      result <= sar;
    end
  end

  // ****************************************************
  // interrupt
  // ****************************************************
  logic done_flag;
  logic irq_mask;
  logic done_set;

  assign done_set = mc_end & ~pending & (cyc == adc_seq_pkg::IRQ_CYCLE);

  // set wins over a same-cycle clear
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      done_flag <= 1'b0;
    end else if (done_set) begin
      done_flag <= 1'b1;
    end else if (status_clr) begin
      done_flag <= 1'b0;
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      irq_mask <= adc_seq_pkg::IRQ_MASK_RESET[0];
    end else if (access_wr && hit_mask) begin
      irq_mask <= I_PWDATA[0];
    end
  end

  assign O_IRQ = done_flag & irq_mask;

  // ****************************************************
  // read data
  // ****************************************************
  logic [7:0] control_view;
  logic [7:0] rd_byte;

  always_comb begin
    control_view = control;
    control_view[adc_seq_pkg::BUSY_BIT] = busy;
  end

  always_comb begin
    rd_byte = 8'h00;
    if (hit_control) begin
      rd_byte = control_view;
    end else if (hit_result) begin
      rd_byte = result;
    end else if (hit_status) begin
      rd_byte = {7'h00, done_flag};
    end else if (hit_mask) begin
      rd_byte = {7'h00, irq_mask};
    end
  end

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_PRDATA <= 32'h0000_0000;
    end else if (setup_phase) begin
      // start register reads as zero
      O_PRDATA <= {24'h00_0000, rd_byte};
    end
  end

  // ****************************************************
  // analog side outputs
  // ****************************************************
  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      O_CHANNEL_SEL <= 3'h0;
      O_SAMPLE_CLOSED <= 1'b0;
      O_DAC_CODE <= 8'h00;
      O_BAUD_GEN_SELECT <= 1'b0;
    end else begin
      O_CHANNEL_SEL <= control[adc_seq_pkg::CHAN_LSB +: 3];
      O_SAMPLE_CLOSED <= (state == adc_seq_pkg::ST_SAMPLE);
      O_DAC_CODE <= sar;
      O_BAUD_GEN_SELECT <= control[adc_seq_pkg::BAUD_BIT];
    end
  end

  // ****************************************************
  // assertions
  // ****************************************************
  sequence seq_start;
    start_wr;
  endsequence

  sequence seq_mc_at(logic [3:0] n);
    mc_end && !pending && !start_wr && cyc == n;
  endsequence

  start_busy_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    seq_start |=> busy && cyc == 4'h0)
    else $error("busy not set by start write");

  start_next_mc_a: assert property (@(posedge I_CORE_CLK)
    disable iff (I_RST)
    (pending && mc_end && !start_wr) |=> cyc == 4'h1)
    else $error("conversion did not begin next machine cycle");

  mc_period_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    mc_end |=> !mc_end ##11 mc_end)
    else $error("machine cycle length wrong");

  final_load_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    seq_mc_at(adc_seq_pkg::PRE_FINAL) |=>
      !busy && result == $past(sar) && cyc == 4'hf)
    else $error("cycle fifteen did not load result");

  // clocks since cycle one began; too long to spell as a repetition
  logic [7:0] conv_clks;

  always_ff @(posedge I_CORE_CLK or posedge I_RST) begin
    if (I_RST) begin
      conv_clks <= 8'h00;
    end else if (cyc == 4'h0 ||
                 (mc_end && cyc == adc_seq_pkg::FINAL_CYCLE)) begin
      conv_clks <= 8'h00;
    end else begin
      conv_clks <= conv_clks + 8'h01;
    end
  end

  conv_length_a: assert property (@(posedge I_CORE_CLK)
    disable iff (I_RST)
    seq_mc_at(adc_seq_pkg::FINAL_CYCLE) |->
      conv_clks == adc_seq_pkg::CONV_LAST_CLK)
    else $error("conversion length not fifteen cycles");

  done_cycle_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    seq_mc_at(adc_seq_pkg::IRQ_CYCLE) |=> done_flag)
    else $error("done flag not set after cycle eleven");

  continuous_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (seq_mc_at(adc_seq_pkg::FINAL_CYCLE) and cont_mode) |=>
      cyc == 4'h1 && busy)
    else $error("continuous mode did not restart");

  single_stop_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (seq_mc_at(adc_seq_pkg::FINAL_CYCLE) and !cont_mode) |=>
      cyc == 4'h0 && !busy)
    else $error("single mode did not stop");

  sample_window_a: assert property (@(posedge I_CORE_CLK)
    disable iff (I_RST)
    $rose(O_SAMPLE_CLOSED) |-> $past(cyc) == 4'h1)
    else $error("sampling did not start at cycle one");

  busy_read_a: assert property (@(posedge I_CORE_CLK) disable iff (I_RST)
    (setup_phase && hit_control) |=>
      O_PRDATA[4] == $past(busy) && O_PRDATA[6:5] == 2'b00)
    else $error("control read view wrong");

  chan_follow_a: assert property (@(posedge I_CORE_CLK)
    disable iff (I_RST)
    (access_wr && hit_control) |=> ##1
      O_CHANNEL_SEL == $past(I_PWDATA[2:0], 2))
    else $error("channel select does not follow control");

endmodule
`default_nettype wire

// ==== adc_analog_model.sv ====
// Purpose: analog side of the converter: channel levels, sample/hold, comparator
// Assumes: one fixed level per channel, packed eight bits per channel
// Notes: comparator output is a plain level; the design synchronises it
`timescale 1ns/1ps
`default_nettype none
module adc_analog_model #(
  parameter logic [63:0] LEVELS = 64'h0000_0000_0000_0000
) (
  input wire logic i_clk,
  input wire logic [2:0] i_channel,
  input wire logic i_sample_closed,
  input wire logic [7:0] i_dac_code,
  output logic o_comp_high
);
  // ****************************************************
  // sample and hold
  // ****************************************************
  logic [7:0] held = 8'h00;
  // switch closed tracks the selected input, open keeps the last level
  always @(posedge i_clk) begin
    if (i_sample_closed) begin
      held <= LEVELS[8 * i_channel +: 8];
    end
  end
  assign o_comp_high = (held >= i_dac_code);
endmodule
`default_nettype wire

// ==== adc_conversion_sequencer_tb_top.sv ====
// Purpose: self-checking bench for the conversion sequencer
// Assumes: zero-wait APB slave, twelve core clocks per machine cycle
// Notes: timings are measured in core clocks from the start write edge
`timescale 1ns/1ps
`default_nettype none
module adc_conversion_sequencer_tb_top;
  // ****************************************************
  // signals
  // ****************************************************
  localparam logic [63:0] LEVELS = 64'h3c7f_8001_a55a_ff00;
  localparam logic [11:0] CTL = adc_seq_pkg::CONTROL_OFFSET;
  localparam logic [11:0] STA = adc_seq_pkg::START_OFFSET;
  localparam logic [11:0] RES = adc_seq_pkg::RESULT_OFFSET;
  localparam logic [11:0] STS = adc_seq_pkg::IRQ_STATUS_OFFSET;
  localparam logic [11:0] MSK = adc_seq_pkg::IRQ_MASK_OFFSET;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready, pslverr, comp, samp, baud, irq;
  logic [2:0] chan;
  logic [7:0] dac;
  int fail_count = 0;
  int num_checks = 0;
  int cyc = 0;
  int samp_cnt = 0;
  adc_conversion_sequencer i_adc_conversion_sequencer (
    .I_CORE_CLK(clk), .I_RST(rst), .I_PSEL(psel), .I_PENABLE(penable),
    .I_PWRITE(pwrite), .I_PADDR(paddr), .I_PWDATA(pwdata),
    .O_PRDATA(prdata), .O_PREADY(pready), .O_PSLVERR(pslverr),
    .I_COMP_HIGH(comp), .O_CHANNEL_SEL(chan), .O_SAMPLE_CLOSED(samp),
    .O_DAC_CODE(dac), .O_BAUD_GEN_SELECT(baud), .O_IRQ(irq));
  adc_analog_model #(.LEVELS(LEVELS)) i_adc_analog_model (
    .i_clk(clk), .i_channel(chan), .i_sample_closed(samp),
    .i_dac_code(dac), .o_comp_high(comp));
  initial forever #12.5 clk = ~clk;
  // ****************************************************
  // helpers
  // ****************************************************
  task automatic finish_test;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // hang guard: a normal run needs about 3000 clocks
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      fail_count++;
      finish_test;
    end
  end
  always @(posedge clk) begin
    if (samp === 1'b1) samp_cnt++;
  end
  task automatic check(input string name, input logic [31:0] got,
                       input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] d, output logic [31:0] rd,
                     output logic err);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic e;
    apb(1'b1, a, d, r, e);
  endtask
  task automatic rd_chk(input string name, input logic [11:0] a,
                        input logic [31:0] exp);
    logic [31:0] r;
    logic e;
    apb(1'b0, a, 32'h0000_0000, r, e);
    check(name, r, exp);
  endtask
  task automatic wait_clks(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task automatic wait_irq(output int t);
    int n = 0;
    while (irq !== 1'b1 && n < 500) begin
      @(posedge clk);
      #1;
      n++;
    end
    t = cyc;
  endtask
  // ****************************************************
  // scenarios
  // ****************************************************
  task automatic t_reset;
    logic [31:0] r;
    logic e;
    check("irq after reset", {31'h0, irq}, 32'h0000_0000);
    rd_chk("control reset", CTL, 32'h0000_0000);
    rd_chk("result reset", RES, 32'h0000_0000);
    rd_chk("mask reset", MSK, 32'h0000_0000);
    rd_chk("start read", STA, 32'h0000_0000);
    apb(1'b0, 12'h0f0, 32'h0000_0000, r, e);
    check("unmapped err", {31'h0, e}, 32'h0000_0001);
    check("unmapped data", r, 32'h0000_0000);
    wait_clks(200);
    rd_chk("no start by read", STS, 32'h0000_0000);
  endtask
  task automatic t_control;
    wr(CTL, 32'h0000_00ff);
    // pin outputs are registered from control: one clock behind
    wait_clks(1);
    check("baud select", {31'h0, baud}, 32'h0000_0001);
    check("channel out", {29'h0, chan}, 32'h0000_0007);
    rd_chk("control bits", CTL, 32'h0000_008f);
    wr(CTL, 32'h0000_0000);
    wait_clks(1);
    check("baud clear", {31'h0, baud}, 32'h0000_0000);
  endtask
  task automatic t_irq_mask;
    wr(STA, 32'h0000_0000);
    wait_clks(200);
    check("masked irq", {31'h0, irq}, 32'h0000_0000);
    rd_chk("done status", STS, 32'h0000_0001);
    wr(MSK, 32'h0000_0001);
    check("unmasked irq", {31'h0, irq}, 32'h0000_0001);
    wr(STS, 32'h0000_0001);
    check("cleared irq", {31'h0, irq}, 32'h0000_0000);
  endtask
  task automatic t_single(input logic [2:0] ch);
    int t0, t1;
    wr(CTL, {29'h0, ch});
    samp_cnt = 0;
    wr(STA, {24'h5a5a_5a, 5'h00, ch});
    t0 = cyc;
    rd_chk("busy at start", CTL, {27'h0, 2'b10, ch});
    wait_irq(t1);
    check("done delay", {31'h0, (t1 - t0 >= 133 && t1 - t0 <= 144)}, 1);
    // busy must clear between 35 and 37 clocks after done
    wait_clks(33);
    rd_chk("busy before end", CTL, {27'h0, 2'b10, ch});
    rd_chk("busy after end", CTL, {29'h0, ch});
    rd_chk("result", RES, {24'h0, LEVELS[8 * ch +: 8]});
    check("sample clocks", samp_cnt, 60);
    wr(STS, 32'h0000_0001);
  endtask
  task automatic t_restart;
    int t0, t1;
    wr(CTL, 32'h0000_0002);
    samp_cnt = 0;
    wr(STA, 32'h0000_0000);
    wait_clks(80);
    wr(CTL, 32'h0000_0005);
    wr(STA, 32'h0000_0000);
    t0 = cyc;
    wait_irq(t1);
    check("restart delay", {31'h0, (t1 - t0 >= 133 && t1 - t0 <= 144)}, 1);
    wait_clks(40);
    rd_chk("restart result", RES, {24'h0, LEVELS[47:40]});
    check("resample clocks", samp_cnt, 120);
    wr(STS, 32'h0000_0001);
  endtask
  task automatic t_cont;
    int t1, t2;
    wr(CTL, 32'h0000_000b);
    wr(STA, 32'h0000_0000);
    wait_irq(t1);
    wr(STS, 32'h0000_0001);
    wait_irq(t2);
    check("repeat period", t2 - t1, 180);
    // back to single mode before the running conversion ends: it must stop
    wr(CTL, 32'h0000_0003);
    wr(STS, 32'h0000_0001);
    rd_chk("cont result", RES, {24'h0, LEVELS[31:24]});
    wait_clks(400);
    check("stopped irq", {31'h0, irq}, 32'h0000_0000);
    rd_chk("stopped busy", CTL, 32'h0000_0003);
  endtask
  // ****************************************************
  // main sequence
  // ****************************************************
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset;
    t_control;
    t_irq_mask;
    for (int ch = 0; ch < 8; ch++) begin
      t_single(3'(ch));
    end
    t_restart;
    t_cont;
    finish_test;
  end
endmodule
`default_nettype wire
